// file: tbw_pkg.sv
package tbw_pkg;

    // Command codes
    localparam logic [7:0] CMD_WRITE_BLOCK = 8'h03;

    // Register byte offsets
    localparam logic [11:0] OFS_CMD      = 12'h000;
    localparam logic [11:0] OFS_ARG0     = 12'h004;
    localparam logic [11:0] OFS_ARG1     = 12'h008;
    localparam logic [11:0] OFS_ARG2     = 12'h00C;
    localparam logic [11:0] OFS_RESULT   = 12'h010;
    localparam logic [11:0] OFS_IRQ_STAT = 12'h014;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h018;
    localparam logic [11:0] OFS_KEY_IDX  = 12'h01C;
    localparam logic [11:0] OFS_KEY_LO   = 12'h020;
    localparam logic [11:0] OFS_KEY_HI   = 12'h024;
    localparam logic [11:0] OFS_BUF_BASE = 12'h100;
    localparam logic [11:0] OFS_BUF_TOP  = 12'h1FF;

    // Argument byte offsets
    localparam int ARG_START_BLK = 0;
    localparam int ARG_COUNT     = 1;
    localparam int ARG_BUF_OFS   = 2;
    localparam int ARG_KEY_SEL   = 3;
    localparam int ARG_KEY       = 4;
    localparam int ARG_KEY_BYTES = 6;
    localparam int ARG_BYTES     = 12;

    // Key selector fields
    localparam int KSEL_TYPE_B   = 7;
    localparam int KSEL_INLINE   = 6;
    localparam int KSEL_IDX_W    = 6;
    localparam int NUM_KEYS      = 40;
    localparam int KEY_W         = 48;

    // Tag geometry
    localparam int BLOCK_BYTES   = 16;
    localparam int BUF_BYTES     = 256;
    localparam logic [7:0] SMALL_SECTOR_LIMIT = 8'h80;
    localparam logic [5:0] LARGE_SECTOR_BASE  = 6'h20;

    // Result codes
    localparam logic [7:0] RES_NO_ERROR  = 8'h00;
    localparam logic [7:0] RES_AUTH_FAIL = 8'h01;
    localparam logic [7:0] RES_WRITE_ERR = 8'h02;
    localparam logic [7:0] RES_PARAM_ERR = 8'h03;
    localparam logic [7:0] RES_UNKNOWN   = 8'h04;
    localparam logic [7:0] RES_RESET     = 8'h00;

    // Interrupt bits, and the busy bit of the command register readback
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;
    localparam int IRQ_W    = 2;
    localparam int BUSY_BIT = 8;

    typedef enum logic [6:0] {
        ST_IDLE      = 7'b0000001,
        ST_AUTH_REQ  = 7'b0000010,
        ST_AUTH_WAIT = 7'b0000100,
        ST_FETCH     = 7'b0001000,
        ST_WR_REQ    = 7'b0010000,
        ST_WR_WAIT   = 7'b0100000,
        ST_DONE      = 7'b1000000
    } tbw_state_t;

endpackage

// file: tbw_buffer.sv
`timescale 1ns/1ps
module tbw_buffer
    import tbw_pkg::*;
#(
    parameter int BYTES = BUF_BYTES
)(
    input  wire logic                       mclk_i,
    input  wire logic                       word_we_i,
    input  wire logic [$clog2(BYTES)-3:0]   word_idx_i,
    input  wire logic [31:0]                word_wdata_i,
    output logic      [31:0]                word_rdata_o,
    input  wire logic [$clog2(BYTES)-1:0]   byte_addr_i,
    output logic      [7:0]                 byte_rdata_o
);

    logic [7:0] mem [BYTES];

    initial
    begin
        if (BYTES < 16 || (BYTES % 4) != 0 || BYTES != (1 << $clog2(BYTES)))
            $error("tbw_buffer: BYTES must be a power of two of at least 16");
    end

    // Little-endian word view for the bus
    always_comb
    begin
        word_rdata_o = {mem[{word_idx_i, 2'b11}], mem[{word_idx_i, 2'b10}],
                        mem[{word_idx_i, 2'b01}], mem[{word_idx_i, 2'b00}]};
    end

    always_ff @(posedge mclk_i)
    begin
        if (word_we_i)
        begin
            mem[{word_idx_i, 2'b00}] <= word_wdata_i[7:0];
            mem[{word_idx_i, 2'b01}] <= word_wdata_i[15:8];
            mem[{word_idx_i, 2'b10}] <= word_wdata_i[23:16];
            mem[{word_idx_i, 2'b11}] <= word_wdata_i[31:24];
        end
    end

    // Registered byte port, one cycle latency
    always_ff @(posedge mclk_i)
    begin
        byte_rdata_o <= mem[byte_addr_i];
    end

endmodule

// file: tbw_keystore.sv
`timescale 1ns/1ps
module tbw_keystore
    import tbw_pkg::*;
#(
    parameter int KEYS = NUM_KEYS
)(
    input  wire logic                    mclk_i,
    input  wire logic                    we_i,
    input  wire logic [KSEL_IDX_W-1:0]   wr_idx_i,
    input  wire logic [KEY_W-1:0]        wr_key_i,
    input  wire logic [KSEL_IDX_W-1:0]   rd_idx_i,
    output logic      [KEY_W-1:0]        rd_key_o
);

    logic [KEY_W-1:0] keys [KEYS];

    initial
    begin
        if (KEYS < 1 || KEYS > (1 << KSEL_IDX_W))
            $error("tbw_keystore: KEYS out of range");
    end

    // Out-of-range index reads zero; the engine refuses it anyway
    always_comb
    begin
        rd_key_o = '0;
        if (int'(rd_idx_i) < KEYS)
            rd_key_o = keys[rd_idx_i];
    end

    always_ff @(posedge mclk_i)
    begin
        if (we_i && int'(wr_idx_i) < KEYS)
            keys[wr_idx_i] <= wr_key_i;
    end

endmodule

// file: tbw_top.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Operation
// - Command code 0x03 selects the multi-block write into a sector-based tag.
// - Arguments are start block, count, buffer offset, key selector, then a 6-byte key.
// - The start block is an absolute block index from 0, not a byte address.
// - The low 6 bits of the key selector pick stored key 0 to 39.
// - Selector bit 7 set means key B, clear means key A.
// - Selector bit 6 set means the key comes from the next 6 argument bytes.
// - The argument key is least significant byte first.
// - The sector holding the first block is authenticated before any write.
// - A failed authentication loads an error result and ends the command.
// - After authentication the first block is written, then following ones while count remains.
// - Written bytes come consecutively from the buffer, starting at the buffer offset.
// - Entering a new sector triggers a fresh authentication with the same key.
// - Full success sets the result to the no-error code.
// - A failed block write stores an error result.
module tbw_top
    import tbw_pkg::*;
(
    input  wire logic           mclk_i,
    input  wire logic           resetn_i,
    input  wire logic           psel_i,
    input  wire logic           penable_i,
    input  wire logic           pwrite_i,
    input  wire logic [11:0]    paddr_i,
    input  wire logic [31:0]    pwdata_i,
    output logic      [31:0]    prdata_o,
    output logic                pready_o,
    output logic                pslverr_o,
    output logic                irq_o,
    output logic                auth_req_o,
    output logic      [5:0]     auth_sector_o,
    output logic      [47:0]    auth_key_o,
    output logic                auth_key_b_o,
    input  wire logic           auth_done_i,
    input  wire logic           auth_ok_i,
    output logic                wr_req_o,
    output logic      [7:0]     wr_block_o,
    output logic      [127:0]   wr_data_o,
    input  wire logic           wr_done_i,
    input  wire logic           wr_ok_i
);

    localparam int BUF_AW = $clog2(BUF_BYTES);

    function automatic logic [5:0] sector_of(input logic [7:0] blk);
        logic [7:0] rel;
        rel = blk - SMALL_SECTOR_LIMIT;
        if (blk < SMALL_SECTOR_LIMIT)
            sector_of = blk[7:2];
        else
            sector_of = LARGE_SECTOR_BASE + {2'b00, rel[7:4]};
    endfunction

    function automatic logic [31:0] pack_args(input logic [7:0] a [ARG_BYTES], input int w);
        pack_args = {a[4*w+3], a[4*w+2], a[4*w+1], a[4*w]};
    endfunction

    tbw_state_t           state;
    logic [7:0]           args [ARG_BYTES];
    logic [7:0]           cmd;
    logic [7:0]           result;
    logic [IRQ_W-1:0]     irq_stat;
    logic [IRQ_W-1:0]     irq_mask;
    logic [KSEL_IDX_W-1:0] key_idx;
    logic [31:0]          key_lo;
    logic [7:0]           cur_blk;
    logic [7:0]           remain;
    logic [5:0]           cur_sector;
    logic [BUF_AW-1:0]    rd_addr;
    logic [4:0]           fcnt;
    logic                 ev_done;
    logic                 ev_err;

    logic                 acc;
    logic                 wr_acc;
    logic                 in_buf;
    logic                 start;
    logic                 busy;
    logic [31:0]          buf_word;
    logic [7:0]           rd_byte;
    logic [KEY_W-1:0]     stored_key;
    logic [KEY_W-1:0]     inline_key;
    logic [12:0]          span;
    logic [7:0]           next_blk;
    logic [31:0]          next_rdata;
    logic                 next_err;

    // Access completes at the edge where pready is seen high
    assign acc     = psel_i && penable_i && pready_o;
    assign wr_acc  = acc && pwrite_i;
    assign in_buf  = paddr_i >= OFS_BUF_BASE && paddr_i <= OFS_BUF_TOP;
    assign busy    = state != ST_IDLE;
    assign start   = wr_acc && paddr_i == OFS_CMD && !busy;
    assign next_blk = cur_blk + 8'h01;

    assign inline_key = {args[ARG_KEY+5], args[ARG_KEY+4], args[ARG_KEY+3],
                         args[ARG_KEY+2], args[ARG_KEY+1], args[ARG_KEY]};

    assign span = 13'(args[ARG_BUF_OFS]) + 13'(args[ARG_COUNT]) * 13'(BLOCK_BYTES);

    tbw_buffer #(
        .BYTES(BUF_BYTES)
    ) u_buffer (
        .mclk_i      (mclk_i),
        .word_we_i   (wr_acc && in_buf),
        .word_idx_i  (paddr_i[BUF_AW-1:2]),
        .word_wdata_i(pwdata_i),
        .word_rdata_o(buf_word),
        .byte_addr_i (rd_addr),
        .byte_rdata_o(rd_byte)
    );

    tbw_keystore #(
        .KEYS(NUM_KEYS)
    ) u_keys (
        .mclk_i  (mclk_i),
        .we_i    (wr_acc && paddr_i == OFS_KEY_HI),
        .wr_idx_i(key_idx),
        .wr_key_i({pwdata_i[15:0], key_lo}),
        .rd_idx_i(args[ARG_KEY_SEL][KSEL_IDX_W-1:0]),
        .rd_key_o(stored_key)
    );

    // Read mux; unmapped addresses answer with an error
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        if (in_buf)
            next_rdata = buf_word;
        else
        begin
            case (paddr_i)
                OFS_CMD:      next_rdata = {23'h0, busy, cmd};
                OFS_ARG0:     next_rdata = pack_args(args, 0);
                OFS_ARG1:     next_rdata = pack_args(args, 1);
                OFS_ARG2:     next_rdata = pack_args(args, 2);
                OFS_RESULT:   next_rdata = {24'h0, result};
                OFS_IRQ_STAT: next_rdata = {30'h0, irq_stat};
                OFS_IRQ_MASK: next_rdata = {30'h0, irq_mask};
                OFS_KEY_IDX:  next_rdata = {26'h0, key_idx};
                OFS_KEY_LO:   next_rdata = key_lo;
                OFS_KEY_HI:   next_rdata = 32'h0000_0000;
                default:      next_err   = 1'b1;
            endcase
        end
    end

    // Bus answer one cycle into the access phase
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end
        else
        begin
            pready_o  <= psel_i && penable_i && !pready_o;
            prdata_o  <= (psel_i && penable_i && !pready_o && !pwrite_i) ? next_rdata : 32'h0;
            pslverr_o <= psel_i && penable_i && !pready_o && next_err;
        end
    end

    // Argument bytes; locked while a command runs
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            for (int i = 0; i < ARG_BYTES; i++)
                args[i] <= 8'h00;
        end
        else if (wr_acc && !busy)
        begin
            for (int w = 0; w < 3; w++)
            begin
                if (paddr_i == OFS_ARG0 + 12'(4 * w))
                begin
                    for (int b = 0; b < 4; b++)
                        args[4*w+b] <= pwdata_i[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            cmd      <= 8'h00;
            irq_mask <= '0;
            key_idx  <= '0;
            key_lo   <= 32'h0000_0000;
        end
        else if (wr_acc)
        begin
            if (start)
                cmd <= pwdata_i[7:0];
            if (paddr_i == OFS_IRQ_MASK)
                irq_mask <= pwdata_i[IRQ_W-1:0];
            if (paddr_i == OFS_KEY_IDX)
                key_idx <= pwdata_i[KSEL_IDX_W-1:0];
            if (paddr_i == OFS_KEY_LO)
                key_lo <= pwdata_i;
        end
    end

    // Sticky status: a new event wins over a same-cycle clear
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            irq_stat <= '0;
            irq_o    <= 1'b0;
        end
        else
        begin
            irq_stat <= (irq_stat & ~((wr_acc && paddr_i == OFS_IRQ_STAT) ?
                         pwdata_i[IRQ_W-1:0] : '0)) | {ev_err, ev_done};
            irq_o    <= |(irq_stat & irq_mask);
        end
    end

    // Command engine
    always_ff @(posedge mclk_i)
    begin
        if (!resetn_i)
        begin
            state         <= ST_IDLE;
            result        <= RES_RESET;
            cur_blk       <= 8'h00;
            remain        <= 8'h00;
            cur_sector    <= 6'h00;
            rd_addr       <= '0;
            fcnt          <= 5'h00;
            ev_done       <= 1'b0;
            ev_err        <= 1'b0;
            auth_req_o    <= 1'b0;
            auth_sector_o <= 6'h00;
            auth_key_o    <= 48'h0000_0000_0000;
            auth_key_b_o  <= 1'b0;
            wr_req_o      <= 1'b0;
            wr_block_o    <= 8'h00;
            wr_data_o     <= 128'h0;
        end
        else
        begin
            ev_done    <= 1'b0;
            ev_err     <= 1'b0;
            auth_req_o <= 1'b0;
            wr_req_o   <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        if (pwdata_i[7:0] != CMD_WRITE_BLOCK)
                        begin
                            result <= RES_UNKNOWN;
                            state  <= ST_DONE;
                        end
                        else if (args[ARG_COUNT] == 8'h00 || span > 13'(BUF_BYTES) ||
                                 (!args[ARG_KEY_SEL][KSEL_INLINE] &&
                                  int'(args[ARG_KEY_SEL][KSEL_IDX_W-1:0]) >= NUM_KEYS))
                        begin
                            result <= RES_PARAM_ERR;
                            state  <= ST_DONE;
                        end
                        else
                        begin
                            cur_blk      <= args[ARG_START_BLK];
                            remain       <= args[ARG_COUNT];
                            rd_addr      <= args[ARG_BUF_OFS][BUF_AW-1:0];
                            auth_key_o   <= args[ARG_KEY_SEL][KSEL_INLINE] ?
                                            inline_key : stored_key;
                            auth_key_b_o <= args[ARG_KEY_SEL][KSEL_TYPE_B];
                            state        <= ST_AUTH_REQ;
                        end
                    end
                end
                ST_AUTH_REQ:
                begin
                    auth_req_o    <= 1'b1;
                    auth_sector_o <= sector_of(cur_blk);
                    cur_sector    <= sector_of(cur_blk);
                    state         <= ST_AUTH_WAIT;
                end
                ST_AUTH_WAIT:
                begin
                    if (auth_done_i)
                    begin
                        if (!auth_ok_i)
                        begin
                            result <= RES_AUTH_FAIL;
                            state  <= ST_DONE;
                        end
                        else
                        begin
                            fcnt  <= 5'h00;
                            state <= ST_FETCH;
                        end
                    end
                end
                ST_FETCH:
                begin
                    if (fcnt <= 5'(BLOCK_BYTES - 1))
                        rd_addr <= rd_addr + 1'b1;
                    if (fcnt != 5'h00)
                        wr_data_o <= {rd_byte, wr_data_o[127:8]};
                    fcnt <= fcnt + 5'h01;
                    if (fcnt == 5'(BLOCK_BYTES))
                        state <= ST_WR_REQ;
                end
                ST_WR_REQ:
                begin
                    wr_req_o   <= 1'b1;
                    wr_block_o <= cur_blk;
                    state      <= ST_WR_WAIT;
                end
                ST_WR_WAIT:
                begin
                    if (wr_done_i)
                    begin
                        if (!wr_ok_i)
                        begin
                            result <= RES_WRITE_ERR;
                            state  <= ST_DONE;
                        end
                        else if (remain == 8'h01)
                        begin
                            result <= RES_NO_ERROR;
                            state  <= ST_DONE;
                        end
                        else
                        begin
                            cur_blk <= next_blk;
                            remain  <= remain - 8'h01;
                            fcnt    <= 5'h00;
                            state   <= (sector_of(next_blk) != cur_sector) ?
                                       ST_AUTH_REQ : ST_FETCH;
                        end
                    end
                end
                ST_DONE:
                begin
                    ev_done <= 1'b1;
                    ev_err  <= result != RES_NO_ERROR;
                    state   <= ST_IDLE;
                end
                default:
                begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// file: tbw_chk.sv
`timescale 1ns/1ps
module tbw_chk
    import tbw_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic        pready_o,
    input  wire logic        pslverr_o,
    input  wire logic        auth_req_o,
    input  wire logic [5:0]  auth_sector_o,
    input  wire logic [47:0] auth_key_o,
    input  wire logic        auth_key_b_o,
    input  wire logic        auth_done_i,
    input  wire logic        auth_ok_i,
    input  wire logic        wr_req_o,
    input  wire logic [7:0]  wr_block_o,
    input  wire logic        wr_done_i,
    input  wire logic        wr_ok_i
);
    logic        pa, pw, authed, seen_a, seen_w, kbq, cmd_wr;
    logic [7:0]  lastb;
    logic [47:0] kq;
    logic [5:0]  blk_sec;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    assign cmd_wr = psel_i && penable_i && pready_o && pwrite_i && paddr_i == OFS_CMD;
    // Sectors of four blocks below 128, sixteen above
    assign blk_sec = wr_block_o[7] ? {3'b100, wr_block_o[6:4]} : {1'b0, wr_block_o[6:2]};

    // Cleared per command: no stale grant
    always_ff @(posedge mclk_i)
    begin
        pa     <= resetn_i && (auth_req_o || (pa && !auth_done_i));
        pw     <= resetn_i && (wr_req_o || (pw && !wr_done_i));
        authed <= resetn_i && !cmd_wr && !auth_req_o &&
                  (authed || (pa && auth_done_i && auth_ok_i));
        seen_a <= resetn_i && !cmd_wr && (seen_a || auth_req_o);
        seen_w <= resetn_i && !cmd_wr && (seen_w || wr_req_o);
        if (auth_req_o)
        begin
            kq  <= auth_key_o;
            kbq <= auth_key_b_o;
        end
        if (wr_req_o)
            lastb <= wr_block_o;
    end

    apb_wait_a:
        assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o)
        else $error("Late APB ready");
    err_with_ready_a:
        assert property (pslverr_o |-> pready_o)
        else $error("Error without ready");
    auth_first_a:
        assert property (wr_req_o |-> authed)
        else $error("Write before auth");
    same_sector_a:
        assert property (wr_req_o |-> blk_sec == auth_sector_o)
        else $error("Write outside sector");
    next_block_a:
        assert property (wr_req_o && seen_w |-> wr_block_o == lastb + 8'h01)
        else $error("Blocks out of order");
    auth_stop_a:
        assert property (pa && auth_done_i && !auth_ok_i |=> !wr_req_o [*8])
        else $error("Write after auth fail");
    write_stop_a:
        assert property (pw && wr_done_i && !wr_ok_i |=> (!wr_req_o && !auth_req_o) [*8])
        else $error("Run after write fail");
    fetch_time_a:
        assert property (pa && auth_done_i && auth_ok_i |-> ##[16:20] wr_req_o)
        else $error("No write after auth");
    same_key_a:
        assert property (auth_req_o && seen_a |-> auth_key_o == kq && auth_key_b_o == kbq)
        else $error("Key changed");

    cover property (pa && auth_done_i && !auth_ok_i);
    cover property (pw && wr_done_i && !wr_ok_i);
    cover property (auth_req_o && seen_w);
endmodule

bind tbw_top tbw_chk u_chk (.*);

// file: tbw_tag_model.sv
`timescale 1ns/1ps
module tbw_tag_model
(
    input  wire logic         mclk_i,
    input  wire logic         resetn_i,
    input  wire logic         auth_req_i,
    input  wire logic [47:0]  auth_key_i,
    input  wire logic         auth_key_b_i,
    input  wire logic         wr_req_i,
    input  wire logic [7:0]   wr_block_i,
    input  wire logic [127:0] wr_data_i,
    input  wire logic [3:0]   dly_i,
    input  wire logic         fail_auth_i,
    input  wire logic [8:0]   fail_blk_i,
    output logic              auth_done_o = 1'b0,
    output logic              auth_ok_o = 1'b0,
    output logic              wr_done_o = 1'b0,
    output logic              wr_ok_o = 1'b0
);
    logic           pa, pw, bad;
    logic [3:0]     ca, cw;
    logic [7:0]     n_auth, n_wr;
    logic [47:0]    key;
    logic           key_b;
    logic [127:0]   mem [256];

    always @(posedge mclk_i)
    begin
        auth_done_o <= 1'b0;
        wr_done_o <= 1'b0;
        // Result lines are not held between answers
        auth_ok_o <= ~auth_ok_o;
        wr_ok_o <= ~wr_ok_o;
        if (!resetn_i)
        begin
            pa <= 1'b0;
            pw <= 1'b0;
            n_auth <= 8'h00;
            n_wr <= 8'h00;
            auth_ok_o <= 1'b0;
        end
        else
        begin
            if (auth_req_i)
            begin
                pa <= 1'b1;
                ca <= dly_i;
                n_auth <= n_auth + 8'h01;
                key <= auth_key_i;
                key_b <= auth_key_b_i;
            end
            else if (pa && ca == 4'h0)
            begin
                pa <= 1'b0;
                auth_done_o <= 1'b1;
                auth_ok_o <= !fail_auth_i;
            end
            else if (pa)
                ca <= ca - 4'h1;
            if (wr_req_i)
            begin
                pw <= 1'b1;
                cw <= dly_i;
                n_wr <= n_wr + 8'h01;
                mem[wr_block_i] <= wr_data_i;
                bad <= {1'b0, wr_block_i} == fail_blk_i;
            end
            else if (pw && cw == 4'h0)
            begin
                pw <= 1'b0;
                wr_done_o <= 1'b1;
                wr_ok_o <= !bad;
            end
            else if (pw)
                cw <= cw - 4'h1;
        end
    end
endmodule

// file: tb_tag_block_write_command.sv
`timescale 1ns/1ps
module tb_tag_block_write_command
    import tbw_pkg::*;
;
    logic mclk_i = 1'b0, resetn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rq;
    logic auth_done_i, auth_ok_i, wr_done_i, wr_ok_i, re, fail_a = 1'b0;
    logic pready_o, pslverr_o, irq_o, auth_req_o, auth_key_b_o, wr_req_o;
    logic [5:0] auth_sector_o;
    logic [47:0] auth_key_o;
    logic [7:0] wr_block_o;
    logic [127:0] wr_data_o;
    logic [3:0] dly = 4'h0;
    logic [8:0] fail_b = 9'h100;
    int err_total = 0, num_checks = 0;

    tbw_top dut (.*);
    tbw_tag_model tag (.mclk_i, .resetn_i, .auth_req_i(auth_req_o),
        .auth_key_i(auth_key_o), .auth_key_b_i(auth_key_b_o), .wr_req_i(wr_req_o),
        .wr_block_i(wr_block_o), .wr_data_i(wr_data_o), .dly_i(dly), .fail_auth_i(fail_a),
        .fail_blk_i(fail_b), .auth_done_o(auth_done_i), .auth_ok_o(auth_ok_i),
        .wr_done_o(wr_done_i), .wr_ok_o(wr_ok_i));

    initial
        forever #2.5 mclk_i = ~mclk_i;

    task automatic report_and_stop();
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [127:0] exp, got);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do
            @(posedge mclk_i);
        while (pready_o !== 1'b1 && ++n < 16);
        rq = prdata_o;
        re = pslverr_o;
        if (n >= 16)
            err_total++;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic run(input logic [7:0] c, input logic [31:0] a0, a1, a2, input logic [7:0] r);
        int n = 0;
        apb(1'b1, OFS_ARG0, a0);
        apb(1'b1, OFS_ARG1, a1);
        apb(1'b1, OFS_ARG2, a2);
        apb(1'b1, OFS_CMD, {24'h0, c});
        // Run time varies with block count
        do
            apb(1'b0, OFS_CMD, 32'h0);
        while (rq[BUSY_BIT] !== 1'b0 && ++n < 100);
        if (n >= 100)
            err_total++;
        apb(1'b0, OFS_RESULT, 32'h0);
        chk("result", r, rq);
    endtask

    function automatic logic [127:0] exp_blk(input int o);
        for (int i = 0; i < 16; i++)
            exp_blk[8*i+:8] = 8'(o + i) ^ 8'hA5;
    endfunction

    initial
    begin
        #200000;
        err_total++;
        report_and_stop();
    end

    initial
    begin
        repeat (2) @(posedge mclk_i);
        resetn_i <= 1'b1;
        @(posedge mclk_i);
        apb(1'b0, OFS_RESULT, 32'h0);
        chk("result reset", RES_RESET, rq);
        apb(1'b0, OFS_IRQ_MASK, 32'h0);
        chk("mask reset", 128'h0, rq);
        apb(1'b0, 12'h0F0, 32'h0);
        chk("unmapped error", 128'h1, re);
        apb(1'b1, OFS_IRQ_MASK, 32'h3);
        apb(1'b0, OFS_IRQ_MASK, 32'h0);
        chk("mask", 128'h3, rq);
        apb(1'b1, OFS_KEY_IDX, 32'h5);
        apb(1'b1, OFS_KEY_LO, 32'hCAFE0123);
        apb(1'b1, OFS_KEY_HI, 32'h0000BEEF);
        for (int w = 0; w < 64; w++)
            apb(1'b1, OFS_BUF_BASE + 12'(4*w), 32'(exp_blk(4*w)));
        dly <= 4'h5;
        run(CMD_WRITE_BLOCK, 32'h8520_0306, 32'h0, 32'h0, RES_NO_ERROR);
        chk("auths", 128'h2, tag.n_auth);
        chk("writes", 128'h3, tag.n_wr);
        chk("stored key", 128'hBEEFCAFE0123, tag.key);
        chk("key b", 128'h1, tag.key_b);
        for (int k = 0; k < 3; k++)
            chk("block", exp_blk(32 + 16 * k), tag.mem[6 + k]);
        chk("irq", 128'h1, irq_o);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("status done", 128'h1, rq);
        apb(1'b1, OFS_IRQ_STAT, 32'h3);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("status clear", 128'h0, rq);
        chk("irq clear", 128'h0, irq_o);
        dly <= 4'h0;
        run(CMD_WRITE_BLOCK, 32'h4000_0280, 32'hC3D4E5F6, 32'h0000A1B2, RES_NO_ERROR);
        chk("inline key", 128'hA1B2C3D4E5F6, tag.key);
        chk("key a", 128'h0, tag.key_b);
        chk("large block", exp_blk(0), tag.mem[128]);
        chk("large next", exp_blk(16), tag.mem[129]);
        chk("auths", 128'h3, tag.n_auth);
        apb(1'b1, OFS_IRQ_STAT, 32'h3);
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        fail_a <= 1'b1;
        run(CMD_WRITE_BLOCK, 32'h0500_0200, 32'h0, 32'h0, RES_AUTH_FAIL);
        chk("no write", 128'h5, tag.n_wr);
        chk("irq masked", 128'h0, irq_o);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk("status error", 128'h3, rq);
        apb(1'b1, OFS_IRQ_MASK, 32'h2);
        apb(1'b0, OFS_IRQ_MASK, 32'h0);
        chk("irq unmasked", 128'h1, irq_o);
        apb(1'b1, OFS_IRQ_STAT, 32'h3);
        fail_a <= 1'b0;
        fail_b <= 9'h001;
        run(CMD_WRITE_BLOCK, 32'h0500_0300, 32'h0, 32'h0, RES_WRITE_ERR);
        chk("stop at fail", 128'h7, tag.n_wr);
        run(CMD_WRITE_BLOCK, 32'h0500_0000, 32'h0, 32'h0, RES_PARAM_ERR);
        run(CMD_WRITE_BLOCK, 32'h05F8_0100, 32'h0, 32'h0, RES_PARAM_ERR);
        run(CMD_WRITE_BLOCK, 32'h2800_0100, 32'h0, 32'h0, RES_PARAM_ERR);
        run(8'h07, 32'h0500_0100, 32'h0, 32'h0, RES_UNKNOWN);
        chk("refused no auth", 128'h5, tag.n_auth);
        report_and_stop();
    end
endmodule
